// file: fifo_flags_top.sv
// Flagged FIFO with edge-selected push and pop ports, output stages and check bits
`timescale 1ns/1ps
// What the document asks of this block
// (R1) Low clear resets pointers and flags at once
// (R2) Accepted push stores word in next slot
// (R3) Each port samples on its selected edge
// (R4) Writer aligns narrow words to the bus; here push_word is always taken as the full 144-bit bus
// (R5) Full high when no free slot remains
// (R6) Near-full while free slots at or below level
// (R7) Push when full dropped, overflow next cycle
// (R8) Accepted pop loads next word into latch
// (R9) Output stage shows word one edge later
// (R10) Empty high when nothing is stored
// (R11) Near-empty while stored words at or below level
// (R12) Pop when empty ignored, underflow next cycle
// (R13) Corrected flag marks repaired single-bit error
// (R14) Uncorrectable flag marks unrepaired errors
// (R15) Common clock delays empty fall one cycle
// (R16) Common clock delays near-empty fall one cycle
// (R17) Without show-ahead, output stage needs a pop
// (R18) Show-ahead presents first word without a pop
// (R19) Latch clears, loads or holds on pop edge
// (R20) Output stage clears, copies or holds
// (R21) No show-ahead with common clock and stage
// (R22) Check bits only at widths 64 or 128
// (R23) Near-empty level ignores output options
// (R24) Common clock bypasses pointer synchronisers
// (R25) Port widths limited to supported values
// (R26) Levels are 14-bit, default sixteen words
// (R27) Generated check byte replaces bus bits
// (R28) Gray pointers cross between the two domains
module fifo_flags_top #(
  parameter int DEPTH = fifo_flags_pkg::DEPTH_DEFAULT
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         push_clk,
  input  wire logic         pop_clk,
  input  wire logic         push_edge_fall,
  input  wire logic         pop_edge_fall,
  input  wire logic         common_clock,
  input  wire logic         show_ahead,
  input  wire logic         outreg_on,
  input  wire logic         ecc_gen_on,
  input  wire logic         ecc_fix_on,
  input  wire logic [13:0]  near_full_level,
  input  wire logic [13:0]  near_empty_level,
  input  wire logic         push_req,
  input  wire logic [143:0] push_word,
  output logic              full,
  output logic              near_full,
  output logic              overflow,
  input  wire logic         pop_req,
  input  wire logic         latch_clr_n,
  input  wire logic         stage_update,
  input  wire logic         stage_clr_n,
  output logic      [143:0] pop_word,
  output logic              empty,
  output logic              near_empty,
  output logic              underflow,
  output logic      [1:0]   corrected_err,
  output logic      [1:0]   uncorrectable_err
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam int CW = (PW > fifo_flags_pkg::THRESH_W) ? PW + 1 : fifo_flags_pkg::THRESH_W + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  store_port_if #(.AW(AW), .DW(fifo_flags_pkg::BUS_W)) store_bus ();

  logic          push_clk_q;
  logic          pop_clk_q;
  logic          push_tick;
  logic          pop_tick;
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] wgray_q;
  logic [PW-1:0] rptr_q;
  logic [PW-1:0] rgray_q;
  logic [PW-1:0] wgray_at_rd;
  logic [PW-1:0] rgray_at_wr;
  logic [PW-1:0] wptr_at_rd;
  logic [PW-1:0] rptr_at_wr;
  logic [CW-1:0] used_w;
  logic [CW-1:0] free_w;
  logic [CW-1:0] mem_cnt;
  logic [CW-1:0] vis_cnt;
  logic          push_ok;
  logic          show_mode;
  logic          latch_valid_q;
  logic          empty_raw;
  logic          near_empty_raw;
  logic          empty_hold_q;
  logic          near_empty_hold_q;
  logic          pop_ok;
  logic          pop_take;
  logic          mem_rd;
  logic          overflow_q;
  logic          underflow_q;
  logic [143:0]  wr_word;
  logic [143:0]  latch_word;
  logic [1:0]    latch_sbit;
  logic [1:0]    latch_dbit;
  logic [143:0]  stage_q;
  logic [1:0]    stage_sbit_q;
  logic [1:0]    stage_dbit_q;
  logic [65:0]   fix_lo;
  logic [65:0]   fix_hi;

  // Gray code to binary
  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    return b;
  endfunction : gray2bin

  // Port clocks arrive as synchronous levels; an active edge becomes a tick
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      push_clk_q <= 1'b0;
      pop_clk_q  <= 1'b0;
    end
    else
    begin
      push_clk_q <= push_clk;
      pop_clk_q  <= pop_clk;
    end
  end

  // Rising or falling edge per port select
  assign push_tick = (push_edge_fall == fifo_flags_pkg::EDGE_FALL) ? (push_clk_q && !push_clk)
                                                                   : (!push_clk_q && push_clk);  // [R3]
  assign pop_tick  = (pop_edge_fall == fifo_flags_pkg::EDGE_FALL) ? (pop_clk_q && !pop_clk)
                                                                  : (!pop_clk_q && pop_clk);     // [R3]

  // Pointer crossings; bypassed in common-clock mode
  gray_cross #(.W(PW)) u_wr_to_rd (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (pop_tick),
    .bypass   (common_clock),
    .gray_in  (wgray_q),
    .gray_out (wgray_at_rd)
  );

  gray_cross #(.W(PW)) u_rd_to_wr (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (push_tick),
    .bypass   (common_clock),
    .gray_in  (rgray_q),
    .gray_out (rgray_at_wr)
  );

  assign wptr_at_rd = gray2bin(wgray_at_rd);          // [R28]
  assign rptr_at_wr = gray2bin(rgray_at_wr);          // [R28]

  // Push side: full asserts at once from our own pointer, clears after the crossing
  assign used_w    = CW'(PW'(wptr_q - rptr_at_wr));
  assign free_w    = DEPTH_C - used_w;
  assign full      = (used_w == DEPTH_C);             // [R5]
  assign near_full = (free_w <= CW'(near_full_level)); // [R6] [R26]
  assign push_ok   = push_tick && push_req && !full;  // [R2]

  // Check bytes overwrite the bus bits when generation is on
  always_comb
  begin
    wr_word = push_word;
    if (ecc_gen_on)
    begin
      wr_word[fifo_flags_pkg::CHK_LO +: fifo_flags_pkg::CHK_W] =
        fifo_flags_pkg::ecc_check(push_word[fifo_flags_pkg::HALF_LO +: fifo_flags_pkg::HALF_DW]);  // [R27]
      wr_word[fifo_flags_pkg::CHK_HI +: fifo_flags_pkg::CHK_W] =
        fifo_flags_pkg::ecc_check(push_word[fifo_flags_pkg::HALF_HI +: fifo_flags_pkg::HALF_DW]);  // [R27]
    end
  end

  // Write pointer, binary and gray
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wptr_q  <= '0;                                  // [R1]
      wgray_q <= '0;
    end
    else if (push_ok)
    begin
      wptr_q  <= wptr_q + PW'(1);                     // [R2]
      wgray_q <= PW'(wptr_q + PW'(1)) ^ (PW'(wptr_q + PW'(1)) >> 1);
    end
  end

  // Overflow reports the push edge after a refused push
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      overflow_q <= 1'b0;                             // [R1]
    else if (push_tick)
      overflow_q <= push_req && full;                 // [R7]
  end

  assign overflow = overflow_q;

  // Show-ahead whenever the output stage is off, or when selected
  assign show_mode = show_ahead || !outreg_on;        // [R17] [R18]

  // Pop side counts; in show-ahead the prefetched latch word still counts as stored,
  // and a word still falling through counts as nothing, so a pop then is refused
  assign mem_cnt        = CW'(PW'(wptr_at_rd - rptr_q));
  assign vis_cnt        = (show_mode && !latch_valid_q) ? CW'(0) : mem_cnt + (show_mode ? CW'(1) : CW'(0));
  assign empty_raw      = (vis_cnt == '0);            // [R10]
  assign near_empty_raw = (vis_cnt <= CW'(near_empty_level));  // [R11] [R23] [R26]

  // Common clock: hold each flag one more pop edge before it falls
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      empty_hold_q      <= 1'b1;                      // [R1]
      near_empty_hold_q <= 1'b1;
    end
    else if (pop_tick)
    begin
      empty_hold_q      <= empty_raw;                 // [R15]
      near_empty_hold_q <= near_empty_raw;            // [R16]
    end
  end

  assign empty      = empty_raw || (common_clock && empty_hold_q);            // [R15]
  assign near_empty = near_empty_raw || (common_clock && near_empty_hold_q);  // [R16]

  // A pop in show-ahead takes the word already in the latch
  assign pop_ok   = pop_tick && pop_req && !empty;    // [R8]
  assign pop_take = pop_ok && (!show_mode || latch_valid_q);
  assign mem_rd   = show_mode ? (pop_tick && (mem_cnt != '0) && (!latch_valid_q || pop_take))  // [R18]
                              : pop_take;             // [R8] [R17]

  // Read pointer and latch occupancy
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rptr_q        <= '0;                            // [R1]
      rgray_q       <= '0;
      latch_valid_q <= 1'b0;
    end
    else
    begin
      if (mem_rd)
      begin
        rptr_q  <= rptr_q + PW'(1);
        rgray_q <= PW'(rptr_q + PW'(1)) ^ (PW'(rptr_q + PW'(1)) >> 1);
      end
      if (mem_rd)
        latch_valid_q <= 1'b1;
      else if (pop_take)
        latch_valid_q <= 1'b0;
    end
  end

  // Underflow reports the pop edge after an ignored pop
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      underflow_q <= 1'b0;                            // [R1]
    else if (pop_tick)
      underflow_q <= pop_req && empty;                // [R12]
  end

  assign underflow = underflow_q;

  // Storage hookup
  assign store_bus.wr_en   = push_ok;
  assign store_bus.wr_addr = wptr_q[AW-1:0];
  assign store_bus.wr_data = wr_word;
  assign store_bus.rd_tick = pop_tick;
  assign store_bus.rd_en   = mem_rd;
  assign store_bus.rd_addr = rptr_q[AW-1:0];
  assign store_bus.clr_n   = latch_clr_n;

  fifo_store #(.DEPTH(DEPTH)) u_store (
    .core_clk (core_clk),
    .resetn   (resetn),
    .port     (store_bus)
  );

  // Decode both halves of the latch word; check bytes pass through unchanged
  assign fix_lo = fifo_flags_pkg::ecc_fix(store_bus.rd_data[fifo_flags_pkg::HALF_LO +: fifo_flags_pkg::HALF_DW],
                                          store_bus.rd_data[fifo_flags_pkg::CHK_LO +: fifo_flags_pkg::CHK_W]);
  assign fix_hi = fifo_flags_pkg::ecc_fix(store_bus.rd_data[fifo_flags_pkg::HALF_HI +: fifo_flags_pkg::HALF_DW],
                                          store_bus.rd_data[fifo_flags_pkg::CHK_HI +: fifo_flags_pkg::CHK_W]);

  always_comb
  begin
    latch_word = store_bus.rd_data;
    latch_sbit = 2'h0;
    latch_dbit = 2'h0;
    if (ecc_fix_on)
    begin
      latch_word[fifo_flags_pkg::HALF_LO +: fifo_flags_pkg::HALF_DW] = fix_lo[63:0];
      latch_word[fifo_flags_pkg::HALF_HI +: fifo_flags_pkg::HALF_DW] = fix_hi[63:0];
      latch_sbit = {fix_hi[64], fix_lo[64]};          // [R13]
      latch_dbit = {fix_hi[65], fix_lo[65]};          // [R14]
    end
  end

  // Output stage: clear or copy only when the update is high
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage_q      <= '0;                             // [R1]
      stage_sbit_q <= 2'h0;
      stage_dbit_q <= 2'h0;
    end
    else if (pop_tick && stage_update)
    begin
      if (!stage_clr_n)
      begin
        stage_q      <= '0;                           // [R20]
        stage_sbit_q <= 2'h0;
        stage_dbit_q <= 2'h0;
      end
      else
      begin
        stage_q      <= latch_word;                   // [R9] [R20]
        stage_sbit_q <= latch_sbit;
        stage_dbit_q <= latch_dbit;
      end
    end
  end

  // Error flags follow whichever stage drives the output word
  assign pop_word          = outreg_on ? stage_q : latch_word;       // [R9]
  assign corrected_err     = outreg_on ? stage_sbit_q : latch_sbit;  // [R13]
  assign uncorrectable_err = outreg_on ? stage_dbit_q : latch_dbit;  // [R14]
endmodule : fifo_flags_top

// file: fifo_flags_pkg.sv
// Shared constants and check-bit helpers for the flagged FIFO
package fifo_flags_pkg;

  // Data bus layout
  localparam int BUS_W      = 144;
  localparam int HALF_LO    = 0;    // Low 64-bit half starts here
  localparam int HALF_HI    = 72;   // High 64-bit half starts here
  localparam int HALF_DW    = 64;   // Protected data bits per half
  localparam int CHK_W      = 8;    // Check bits per half
  localparam int CHK_LO     = 64;   // Check byte of the low half
  localparam int CHK_HI     = 136;  // Check byte of the high half
  localparam int HAM_W      = 7;    // Syndrome bits without overall parity
  localparam int HAM_FIRST  = 3;    // First data position in the code word

  // Level settings
  localparam int          THRESH_W       = 14;
  localparam logic [13:0] THRESH_DEFAULT = 14'h0010;
  localparam logic [13:0] THRESH_MAX     = 14'h3fff;

  // Edge select encodings
  localparam logic EDGE_RISE = 1'b0;
  localparam logic EDGE_FALL = 1'b1;

  // Default depth of 144-bit entries, 144 kb of storage in all
  localparam int DEPTH_DEFAULT = 1024;

  // Check byte of a 64-bit word: single-error Hamming bits plus overall parity
  function automatic logic [7:0] ecc_check(input logic [63:0] d);
    logic [7:0] c;
    int         p;
    c = 8'h00;
    p = HAM_FIRST;
    for (int n = 0; n < HALF_DW; n++)
    begin
      if ((p & (p - 1)) == 0)
        p++;
      c[HAM_W-1:0] = c[HAM_W-1:0] ^ ({HAM_W{d[n]}} & p[HAM_W-1:0]);
      p++;
    end
    c[HAM_W] = ^{d, c[HAM_W-1:0]};
    return c;
  endfunction : ecc_check

  // Returns {uncorrectable, corrected, repaired data}
  function automatic logic [65:0] ecc_fix(input logic [63:0] d, input logic [7:0] s);
    logic [7:0]       c;
    logic [HAM_W-1:0] syn;
    logic             par;
    logic [63:0]      f;
    int               p;
    c   = ecc_check(d);
    syn = c[HAM_W-1:0] ^ s[HAM_W-1:0];
    par = ^{d, s};
    f   = d;
    p   = HAM_FIRST;
    for (int n = 0; n < HALF_DW; n++)
    begin
      if ((p & (p - 1)) == 0)
        p++;
      if (par && (syn == p[HAM_W-1:0]))
        f[n] = ~f[n];
      p++;
    end
    return {(syn != 7'h00) && !par, par, f};
  endfunction : ecc_fix

endpackage : fifo_flags_pkg

// file: store_port_if.sv
// Carrier between the FIFO control logic and its storage array
`timescale 1ns/1ps
interface store_port_if #(
  parameter int AW = 10,
  parameter int DW = 144
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic          rd_tick;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic          clr_n;
  logic [DW-1:0] rd_data;

  modport ctl (output wr_en, wr_addr, wr_data, rd_tick, rd_en, rd_addr, clr_n, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_tick, rd_en, rd_addr, clr_n, output rd_data);
endinterface : store_port_if

// file: fifo_store.sv
// Storage array with a registered output latch stage
`timescale 1ns/1ps
module fifo_store #(
  parameter int DEPTH = fifo_flags_pkg::DEPTH_DEFAULT
) (
  input  wire logic   core_clk,
  input  wire logic   resetn,
  store_port_if.mem   port
);
  logic [fifo_flags_pkg::BUS_W-1:0] store_q [DEPTH];
  logic [fifo_flags_pkg::BUS_W-1:0] latch_q;

  // Array write; no reset so it maps onto block memory
  always_ff @(posedge core_clk)
  begin
    if (port.wr_en)
      store_q[port.wr_addr] <= port.wr_data;
  end

  // Output latch: clear wins over a load on the same pop edge
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      latch_q <= '0;
    else if (port.rd_tick && !port.clr_n)
      latch_q <= '0;                                  // [R19]
    else if (port.rd_en)
      latch_q <= store_q[port.rd_addr];               // [R8] [R19]
  end

  assign port.rd_data = latch_q;
endmodule : fifo_store

// file: gray_cross.sv
// Two-stage crossing of a gray pointer, with a bypass for common-clock use
`timescale 1ns/1ps
module gray_cross #(
  parameter int W = 11
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         tick,
  input  wire logic         bypass,
  input  wire logic [W-1:0] gray_in,
  output logic      [W-1:0] gray_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Stages advance on the destination side's active edge only
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else if (tick)
    begin
      meta_q <= gray_in;                              // [R28]
      sync_q <= meta_q;
    end
  end

  // One source clock means no crossing, so skip the stages
  assign gray_out = bypass ? gray_in : sync_q;        // [R24]
endmodule : gray_cross

// file: fifo_flags_props.sv
// Port-level assertions for the flagged FIFO
`timescale 1ns/1ps
module fifo_flags_props #(
  parameter int DEPTH = 1024
) (
  input wire logic         core_clk,
  input wire logic         resetn,
  input wire logic         push_clk,
  input wire logic         pop_clk,
  input wire logic         push_edge_fall,
  input wire logic         pop_edge_fall,
  input wire logic         outreg_on,
  input wire logic         ecc_fix_on,
  input wire logic         push_req,
  input wire logic         full,
  input wire logic         near_full,
  input wire logic         overflow,
  input wire logic         pop_req,
  input wire logic         latch_clr_n,
  input wire logic         stage_update,
  input wire logic         stage_clr_n,
  input wire logic [143:0] pop_word,
  input wire logic         empty,
  input wire logic         near_empty,
  input wire logic         underflow
);
  logic push_prev_q;
  logic pop_prev_q;
  logic push_tick;
  logic pop_tick;

  // Port clock history, cleared like the block's own so ticks line up
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      push_prev_q <= 1'b0;
      pop_prev_q  <= 1'b0;
    end
    else
    begin
      push_prev_q <= push_clk;
      pop_prev_q  <= pop_clk;
    end
  end

  // Active port edges as selected
  assign push_tick = push_edge_fall ? (push_prev_q & ~push_clk) : (~push_prev_q & push_clk);
  assign pop_tick  = pop_edge_fall ? (pop_prev_q & ~pop_clk) : (~pop_prev_q & pop_clk);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_push_refused;
    push_tick && push_req && full;
  endsequence
  sequence s_pop_refused;
    pop_tick && pop_req && empty;
  endsequence
  sequence s_stage_idle;
    outreg_on && !ecc_fix_on && !(pop_tick && stage_update);
  endsequence

  a_overflow_raise: assert property (s_push_refused |=> overflow)
    else $error("overflow missing after refused push");
  a_overflow_drop: assert property (push_tick && !(push_req && full) |=> !overflow)
    else $error("overflow set without refused push");
  a_underflow_raise: assert property (s_pop_refused |=> underflow)
    else $error("underflow missing after refused pop");
  a_underflow_hold: assert property (!pop_tick |=> $stable(underflow))
    else $error("underflow changed between pop ticks");
  a_full_near: assert property (full |-> near_full)
    else $error("full without near full");
  a_empty_near: assert property (empty |-> near_empty)
    else $error("empty without near empty");
  a_empty_wait_tick: assert property (empty && !pop_tick |=> empty)
    else $error("empty fell without a pop tick");
  a_stage_hold: assert property (s_stage_idle |=> $stable(pop_word))
    else $error("output stage changed without update");
  a_stage_clear: assert property (outreg_on && pop_tick && stage_update && !stage_clr_n |=> pop_word == 144'h0)
    else $error("output stage not cleared");
  a_latch_clear: assert property (!outreg_on && pop_tick && !latch_clr_n |=> pop_word == 144'h0)
    else $error("output latch not cleared");
endmodule : fifo_flags_props

bind fifo_flags_top fifo_flags_props #(.DEPTH(DEPTH)) props (
  .core_clk(core_clk), .resetn(resetn), .push_clk(push_clk), .pop_clk(pop_clk),
  .push_edge_fall(push_edge_fall), .pop_edge_fall(pop_edge_fall), .outreg_on(outreg_on),
  .ecc_fix_on(ecc_fix_on), .push_req(push_req), .full(full), .near_full(near_full), .overflow(overflow),
  .pop_req(pop_req), .latch_clr_n(latch_clr_n), .stage_update(stage_update), .stage_clr_n(stage_clr_n),
  .pop_word(pop_word), .empty(empty), .near_empty(near_empty), .underflow(underflow));

// file: fabric_clocks.sv
// Far-side fabric model: both port clocks from one source
`timescale 1ns/1ps
module fabric_clocks (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic push_run,
  input  wire logic pop_run,
  output logic      push_clk,
  output logic      pop_clk
);
  // Clocks rest low through reset so release brings no stray tick; run low stalls a side
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      push_clk <= 1'b0;
      pop_clk  <= 1'b0;
    end
    else
    begin
      push_clk <= push_clk ^ push_run;
      pop_clk  <= pop_clk ^ pop_run;
    end
  end
endmodule : fabric_clocks

// file: dual_clock_fifo_with_flags_test.sv
// Self-checking bench for the flagged FIFO
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module dual_clock_fifo_with_flags_test;
  typedef struct packed {
    logic [143:0] word;
    logic [1:0]   corr;
    logic [1:0]   unc;
  } note_t;
  localparam int DEPTH = 8;
  logic         core_clk, resetn, push_clk, pop_clk, push_run, pop_run;
  logic         push_edge_fall, pop_edge_fall, common_clock, outreg_on, ecc_fix_on;
  logic         push_req, pop_req, latch_clr_n, stage_update, stage_clr_n;
  logic         full, near_full, overflow, empty, near_empty, underflow;
  logic [143:0] push_word, pop_word;
  logic [1:0]   corrected_err, uncorrectable_err;
  logic [159:0] rnd;
  note_t        exp_q[$];
  note_t        n;
  int           error_cnt, n_tests, cycles, seed, i;
  bit           due, armed, pprev, pt;

  fabric_clocks far (.core_clk(core_clk), .resetn(resetn), .push_run(push_run), .pop_run(pop_run),
                     .push_clk(push_clk), .pop_clk(pop_clk));
  // Show-ahead is never selected, so the unsupported mix never arises
  fifo_flags_top #(.DEPTH(DEPTH)) dut (
    .core_clk(core_clk), .resetn(resetn), .push_clk(push_clk), .pop_clk(pop_clk),
    .push_edge_fall(push_edge_fall), .pop_edge_fall(pop_edge_fall), .common_clock(common_clock),
    .show_ahead(1'b0), .outreg_on(outreg_on), .ecc_gen_on(1'b0), .ecc_fix_on(ecc_fix_on),
    .near_full_level(14'h0002), .near_empty_level(14'h0003), .push_req(push_req),
    .push_word(push_word), .full(full), .near_full(near_full), .overflow(overflow), .pop_req(pop_req),
    .latch_clr_n(latch_clr_n), .stage_update(stage_update), .stage_clr_n(stage_clr_n),
    .pop_word(pop_word), .empty(empty), .near_empty(near_empty), .underflow(underflow),
    .corrected_err(corrected_err), .uncorrectable_err(uncorrectable_err));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Watcher: a staged word is due a cycle after the stage loads, a latched one at its pop tick
  always @(posedge core_clk)
  begin
    pt = pop_edge_fall ? (pprev && !pop_clk) : (!pprev && pop_clk);
    if (due || (pt && pop_req && !empty && !outreg_on))
    begin
      n = exp_q.pop_front();
      `CHK("pop_word", n.word, pop_word)
      `CHK("corrected_err", n.corr, corrected_err)
      `CHK("uncorrectable_err", n.unc, uncorrectable_err)
    end
    due = pt && outreg_on && armed && stage_update;
    if (due)
      armed = 1'b0;
    if (pt && pop_req && !empty)
      armed = armed || outreg_on;
    pprev = pop_clk;
    if (!resetn)
    begin
      due = 1'b0;
      armed = 1'b0;
      pprev = 1'b0;
    end
  end

  // Watchdog: the run needs well under this many cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      $display("ERROR watchdog expected finish seen hang");
      summarize();
    end
  end

  task automatic reset_cfg(input logic cc, input logic fall, input logic oreg, input logic fix);
    @(posedge core_clk);
    resetn         <= 1'b0;
    push_run       <= 1'b0;
    pop_run        <= 1'b0;
    common_clock   <= cc;
    push_edge_fall <= fall;
    pop_edge_fall  <= fall;
    outreg_on      <= oreg;
    ecc_fix_on     <= fix;
    repeat (3) @(posedge core_clk);
    resetn   <= 1'b1;
    push_run <= 1'b1;
    pop_run  <= 1'b1;
    @(posedge core_clk);
  endtask : reset_cfg

  // Each request is held for a whole port clock period, so exactly one tick sees it
  task automatic push(input logic [143:0] w, input note_t e, input bit keep);
    if (keep)
      exp_q.push_back(e);
    push_req  <= 1'b1;
    push_word <= w;
    repeat (2) @(posedge core_clk);
    push_req <= 1'b0;
    @(posedge core_clk);
  endtask : push

  // Full-width random words keep every bus bit in play
  task automatic rpush();
    rnd = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    push(rnd[143:0], {rnd[143:0], 4'h0}, 1'b1);
  endtask : rpush

  task automatic pop();
    pop_req <= 1'b1;
    repeat (2) @(posedge core_clk);
    pop_req <= 1'b0;
    @(posedge core_clk);
  endtask : pop

  task automatic wait_data();
    for (int k = 0; k < 40 && empty !== 1'b0; k++)
      @(posedge core_clk);
    `CHK("empty", 1'b0, empty)
  endtask : wait_data

  task automatic end_test(input string nm);
    $display("test %s finished, %0d checks so far", nm, n_tests);
  endtask : end_test

  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  initial
  begin
    seed = 86;
    resetn = 1'b0;
    {push_run, pop_run, push_req, pop_req} = 4'h0;
    {push_edge_fall, pop_edge_fall, common_clock, outreg_on, ecc_fix_on} = 5'h00;
    {latch_clr_n, stage_update, stage_clr_n} = 3'h7;
    push_word = 144'h0;
    // Fill past capacity with the pop side stalled, then drain and underrun
    reset_cfg(1'b1, 1'b0, 1'b0, 1'b0);
    `CHK("empty", 1'b1, empty)
    `CHK("near_empty", 1'b1, near_empty)
    `CHK("full", 1'b0, full)
    pop_run <= 1'b0;
    for (i = 0; i < DEPTH; i++)
    begin
      rpush();
      if (i == 0) `CHK("empty", 1'b1, empty)
      if (i == DEPTH - 4) `CHK("near_full", 1'b0, near_full)
      if (i == DEPTH - 3) `CHK("near_full", 1'b1, near_full)
    end
    `CHK("full", 1'b1, full)
    push(144'h0, 148'h0, 1'b0);
    `CHK("overflow", 1'b1, overflow)
    pop_run <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK("empty", 1'b0, empty)
    `CHK("near_empty", 1'b0, near_empty)
    for (i = 0; i < DEPTH; i++)
      pop();
    repeat (4) @(posedge core_clk);
    `CHK("pending", 0, exp_q.size())
    `CHK("near_empty", 1'b1, near_empty)
    pop();
    `CHK("underflow", 1'b1, underflow)
    end_test("fill");
    // Separate domains, falling edges, output stage with held and cleared updates
    reset_cfg(1'b0, 1'b1, 1'b1, 1'b0);
    for (i = 0; i < 3; i++)
      rpush();
    wait_data();
    for (i = 0; i < 3; i++)
      pop();
    repeat (6) @(posedge core_clk);
    `CHK("pending", 0, exp_q.size())
    stage_update <= 1'b0;
    rpush();
    wait_data();
    pop();
    repeat (6) @(posedge core_clk);
    `CHK("pending", 1, exp_q.size())
    stage_update <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK("pending", 0, exp_q.size())
    stage_clr_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    stage_clr_n <= 1'b1;
    @(posedge core_clk);
    `CHK("pop_word", 144'h0, pop_word)
    end_test("stage");
    // Decoder on 64-bit halves with hand-made check bytes of zero
    reset_cfg(1'b1, 1'b0, 1'b0, 1'b1);
    push(144'h0, {144'h0, 4'h0}, 1'b1);
    push({71'h0, 1'b1, 71'h0, 1'b1}, {144'h0, 2'h3, 2'h0}, 1'b1);
    push(144'h3, {144'h3, 2'h0, 2'h1}, 1'b1);
    wait_data();
    for (i = 0; i < 3; i++)
      pop();
    repeat (3) @(posedge core_clk);
    `CHK("pending", 0, exp_q.size())
    latch_clr_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    latch_clr_n <= 1'b1;
    @(posedge core_clk);
    `CHK("pop_word", 144'h0, pop_word)
    end_test("ecc");
    // Clear in mid-run acts at once, between clock edges
    push(144'h5, 148'h0, 1'b0);
    repeat (4) @(posedge core_clk);
    resetn <= 1'b0;
    #20;
    `CHK("empty", 1'b1, empty)
    `CHK("full", 1'b0, full)
    end_test("clear");
    summarize();
  end
endmodule : dual_clock_fifo_with_flags_test
